// *** bench/gpi_pin_model.sv ***
// Pin model: resolves the nine port lines from the port drive and an outside driver.
// Assumes the bench drives ext_val/ext_en; undriven lines fall to the pull-down.
`timescale 1ns/1ps
module gpi_pin_model (
  input  wire logic [8:0] line_out,
  input  wire logic [8:0] line_oe,
  input  wire logic [8:0] ext_val,
  input  wire logic [8:0] ext_en,
  output logic      [8:0] line_in
);
  // Port drive wins over the outside driver so contention never shows as unknown
  always_comb begin
    for (int i = 0; i < 9; i++) begin
      if (line_oe[i]) begin
        line_in[i] = line_out[i];
      end else if (ext_en[i]) begin
        line_in[i] = ext_val[i];
      end else begin
        line_in[i] = 1'b0;
      end
    end
  end
endmodule

// *** bench/gpi_port_bench.sv ***
// Self-checking bench for the I/O port: register tasks, pin stimulus, event checks.
// Assumes gpi_pkg is compiled first and the pin model resolves the lines.
`timescale 1ns/1ps
module gpi_port_bench;
  logic        clk_sys;
  logic        rst;
  logic [8:0]  reg_addr;
  logic [31:0] reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [31:0] reg_rdata;
  logic [8:0]  line_in;
  logic [8:0]  line_out;
  logic [8:0]  line_oe;
  logic [7:0]  alt_out;
  logic [7:0]  alt_oe;
  logic        aux;
  logic        sync;
  logic        trip_n;
  logic        irq_n;
  logic [8:0]  ext_val;
  logic [8:0]  ext_en;
  int          num_errors;
  int          checked;
  int          cycle_cnt;

  gpi_port u_gpi_port (.clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .line_in(line_in), .line_out(line_out),
    .line_oe(line_oe), .alt_out(alt_out), .alt_oe(alt_oe), .aux_pwm_out_zero(aux),
    .pwm_period_sync(sync), .pwm_fault_trip_n(trip_n), .peripheral_irq_line_n(irq_n));
  gpi_pin_model u_gpi_pin_model (.line_out(line_out), .line_oe(line_oe), .ext_val(ext_val),
    .ext_en(ext_en), .line_in(line_in));

  // 200 MHz clock
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  // Hang guard: the whole sequence needs about 130 cycles
  always @(posedge clk_sys) begin
    cycle_cnt <= cycle_cnt + 1;
    if (cycle_cnt == 3000) begin
      num_errors++;
      final_report();
    end
  end

  task automatic final_report;
    $display("Comparisons %0d, mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH at %0t: got 0x%08h expected 0x%08h", $time, got, exp);
    end
  endtask

  // Single-cycle write strobe
  task automatic wr(input logic [6:0] idx, input logic [31:0] d);
    @(posedge clk_sys);
    reg_wr    <= 1'b1;
    reg_addr  <= {idx, 2'b00};
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe, so sample just past that edge
  task automatic rchk(input logic [6:0] idx, input logic [31:0] exp);
    @(posedge clk_sys);
    reg_rd   <= 1'b1;
    reg_addr <= {idx, 2'b00};
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, exp);
  endtask

  task automatic wait_chk_irq(input logic exp);
    repeat (5) @(posedge clk_sys);
    #1 chk(32'(irq_n), 32'(exp));
  endtask

  initial begin
    num_errors = 0; checked = 0; cycle_cnt = 0;
    rst = 1'b1; reg_addr = 9'h000; reg_wdata = 32'h0; reg_wr = 1'b0; reg_rd = 1'b0;
    alt_out = 8'h00; alt_oe = 8'h00; aux = 1'b0; sync = 1'b0; trip_n = 1'b1;
    ext_val = 9'h000; ext_en = 9'h000;
    repeat (3) @(posedge clk_sys);
    rst <= 1'b0;
    // Reset state with the lines left floating
    rchk(gpi_pkg::IDX_FUNC_SEL, 32'hFF);
    rchk(gpi_pkg::IDX_DIR_LOW, 32'h0);
    rchk(gpi_pkg::IDX_DIR_HIGH, 32'h0);
    rchk(gpi_pkg::IDX_IEN_LOW, 32'h0);
    rchk(gpi_pkg::IDX_IEN_HIGH, 32'h0);
    rchk(gpi_pkg::IDX_DATA_LOW, 32'h0);
    rchk(gpi_pkg::IDX_DATA_HIGH, 32'h2);
    rchk(7'h7F, 32'h0);
    chk(32'(line_oe), 32'h0);
    chk(32'(irq_n), 32'h1);
    // Outputs on lines 0-3 and 8, outside drive on 4-7
    wr(gpi_pkg::IDX_DIR_LOW, 32'h0F);
    wr(gpi_pkg::IDX_DATA_LOW, 32'hA5);
    wr(gpi_pkg::IDX_DIR_HIGH, 32'h1);
    wr(gpi_pkg::IDX_DATA_HIGH, 32'h3);
    ext_en <= 9'h0F0;
    ext_val <= 9'h0A0;
    // Let the outside levels pass both synchroniser stages before reading them
    repeat (2) @(posedge clk_sys);
    rchk(gpi_pkg::IDX_DATA_LOW, 32'hA5);
    chk({23'h0, line_oe, line_out & line_oe}, {23'h0, 9'h10F, 9'h105});
    // Alternate functions on lines 0 and 8; the I/O values would differ
    wr(gpi_pkg::IDX_FUNC_SEL, 32'hFE);
    wr(gpi_pkg::IDX_DATA_HIGH, 32'h1);
    alt_oe <= 8'h01;
    @(posedge clk_sys);
    #1 chk({28'h0, line_oe[8], line_oe[0], line_out[8], line_out[0]}, 32'hC);
    // Line 2 alternate, line 3 output, line 0 not enabled: only 1 and 4 may flag
    alt_oe <= 8'h00;
    ext_en <= 9'h1FF;
    ext_val <= 9'h000;
    wr(gpi_pkg::IDX_DATA_HIGH, 32'h2);
    wr(gpi_pkg::IDX_DIR_HIGH, 32'h0);
    wr(gpi_pkg::IDX_FUNC_SEL, 32'hFB);
    wr(gpi_pkg::IDX_DIR_LOW, 32'h08);
    wr(gpi_pkg::IDX_DATA_LOW, 32'h00);
    wr(gpi_pkg::IDX_IEN_LOW, 32'h1E);
    wr(gpi_pkg::IDX_DATA_LOW, 32'h08);
    ext_val <= 9'h11F;
    wait_chk_irq(1'b0);
    rchk(gpi_pkg::IDX_FLAG_LOW, 32'h12);
    rchk(gpi_pkg::IDX_FLAG_LOW, 32'h0);
    wait_chk_irq(1'b1);
    // Falling edge on line 8
    wr(gpi_pkg::IDX_IEN_HIGH, 32'h1);
    ext_val <= 9'h01F;
    wait_chk_irq(1'b0);
    rchk(gpi_pkg::IDX_FLAG_HIGH, 32'h1);
    rchk(gpi_pkg::IDX_FLAG_HIGH, 32'h0);
    // Line 4 falls so its flag lands on the edge that takes the read
    @(posedge clk_sys);
    ext_val <= 9'h00F;
    @(posedge clk_sys);
    @(posedge clk_sys);
    reg_rd   <= 1'b1;
    reg_addr <= {gpi_pkg::IDX_FLAG_LOW, 2'b00};
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    rchk(gpi_pkg::IDX_FLAG_LOW, 32'h10);
    // Sync event plus a line event: the line keeps the interrupt low after status read
    sync <= 1'b1;
    ext_val <= 9'h00D;
    wait_chk_irq(1'b0);
    rchk(gpi_pkg::IDX_PERIPH_STAT, 32'h2);
    wait_chk_irq(1'b0);
    rchk(gpi_pkg::IDX_FLAG_LOW, 32'h02);
    wait_chk_irq(1'b1);
    // Trip pin fall, sync fall ignored, then a soft trip
    sync <= 1'b0;
    trip_n <= 1'b0;
    wait_chk_irq(1'b0);
    rchk(gpi_pkg::IDX_PERIPH_STAT, 32'h1);
    trip_n <= 1'b1;
    wr(gpi_pkg::IDX_SOFT_TRIP, 32'h0);
    wait_chk_irq(1'b0);
    rchk(gpi_pkg::IDX_PERIPH_STAT, 32'h1);
    rchk(gpi_pkg::IDX_PERIPH_STAT, 32'h0);
    wait_chk_irq(1'b1);
    // Serial pins handed over; line 3 stays I/O until an external serial clock needs it
    wr(gpi_pkg::IDX_FUNC_SEL, 32'hD8);
    alt_oe <= 8'hFF;
    @(posedge clk_sys);
    #1 chk(32'(line_oe), 32'h2F);
    wr(gpi_pkg::IDX_FUNC_SEL, 32'hD0);
    alt_oe <= 8'hF7;
    @(posedge clk_sys);
    #1 chk(32'(line_oe), 32'h27);
    final_report();
  end
endmodule

// *** include/gpi_pkg.sv ***
// Package for the nine-line programmable I/O port with peripheral interrupt merge.
// Assumes a 200 MHz system clock and a simple strobe-based register port.
package gpi_pkg;

  // Register indices: printed offsets are not word multiples, so byte address = 4 * index
  localparam logic [6:0] IDX_DIR_LOW      = 7'h04;
  localparam logic [6:0] IDX_DATA_LOW     = 7'h05;
  localparam logic [6:0] IDX_IEN_LOW      = 7'h06;
  localparam logic [6:0] IDX_FLAG_LOW     = 7'h07;
  localparam logic [6:0] IDX_PERIPH_STAT  = 7'h17;
  localparam logic [6:0] IDX_DIR_HIGH     = 7'h44;
  localparam logic [6:0] IDX_DATA_HIGH    = 7'h45;
  localparam logic [6:0] IDX_IEN_HIGH     = 7'h46;
  localparam logic [6:0] IDX_FLAG_HIGH    = 7'h47;
  localparam logic [6:0] IDX_FUNC_SEL     = 7'h49;
  localparam logic [6:0] IDX_SOFT_TRIP    = 7'h61;

  localparam int ADDR_W = 9;
  localparam int DATA_W = 32;

  // Field positions
  localparam int DATA_HIGH_LEVEL_BIT = 0;
  localparam int DATA_HIGH_MODE_BIT  = 1;
  localparam int STAT_TRIP_BIT       = 0;
  localparam int STAT_SYNC_BIT       = 1;

  // Reset values
  localparam logic [7:0] FUNC_SEL_RST  = 8'hFF;
  localparam logic [7:0] DIR_LOW_RST   = 8'h00;
  localparam logic       DIR_HIGH_RST  = 1'b0;
  localparam logic [7:0] IEN_LOW_RST   = 8'h00;
  localparam logic       IEN_HIGH_RST  = 1'b0;
  localparam logic [7:0] DATA_LOW_RST  = 8'h00;
  localparam logic [1:0] DATA_HIGH_RST = 2'h2;

  // Pin bundle for the nine lines
  typedef struct packed {
    logic [8:0] dout;
    logic [8:0] oe;
  } gpi_pin_drive_t;

endpackage

// *** verilog/gpi_port.sv ***
// Nine-line I/O port with change-of-state flags and a merged peripheral interrupt.
// Assumes pin inputs and peripheral event inputs are synchronous-capable levels; the
// pins themselves are resolved (pull-down, tri-state) outside this module.
`timescale 1ns/1ps

// How it works
// - Function select: one bit per line 0-7, set means general I/O, clear alternate.
// - Function select resets to all ones, so all shared lines start as I/O.
// - Line 8 function comes from high data bit 1: one I/O, zero aux PWM.
// - Eight-bit low and one-bit high direction registers; one is output, zero input.
// - Both direction registers clear on reset, all lines become inputs.
// - Data reads return line levels; writes drive lines configured as outputs.
// - Line interrupts need I/O mode, input direction and its enable bit set.
// - Any edge on an enabled input sets its flag and the shared port request.
// - Reading a change flag register returns its bits then clears them, except bits with a new edge in that cycle.
// - Reset clears both interrupt enable registers.
// - Unconnected lines read low through an external pull-down after reset.
// - Sync, trip and port interrupts merge onto one peripheral interrupt line.
// - A rising edge of the PWM sync pulse raises a sync interrupt.
// - Trip falling edge or a soft trip register write raises a trip interrupt.
// - Active-low interrupt holds while any latched event remains unacknowledged.
// - Reading peripheral status clears and acknowledges trip and sync bits.
module gpi_port (
  input  wire logic                          clk_sys,
  input  wire logic                          rst,
  input  wire logic [gpi_pkg::ADDR_W-1:0]    reg_addr,
  input  wire logic [gpi_pkg::DATA_W-1:0]    reg_wdata,
  input  wire logic                          reg_wr,
  input  wire logic                          reg_rd,
  output logic      [gpi_pkg::DATA_W-1:0]    reg_rdata,
  input  wire logic [8:0]                    line_in,
  output logic      [8:0]                    line_out,
  output logic      [8:0]                    line_oe,
  input  wire logic [7:0]                    alt_out,
  input  wire logic [7:0]                    alt_oe,
  input  wire logic                          aux_pwm_out_zero,
  input  wire logic                          pwm_period_sync,
  input  wire logic                          pwm_fault_trip_n,
  output logic                               peripheral_irq_line_n
);

  // Software state
  logic [7:0] func_sel_r;
  logic [7:0] dir_low_r;
  logic       dir_high_r;
  logic [7:0] data_low_r;
  logic [1:0] data_high_r;
  logic [7:0] ien_low_r;
  logic       ien_high_r;
  logic [7:0] flag_low_r;
  logic       flag_high_r;
  logic       stat_trip_r;
  logic       stat_sync_r;
  logic [gpi_pkg::DATA_W-1:0] rdata_r;

  // Synchronisers and edge history
  logic [8:0] line_s1_r;
  logic [8:0] line_s2_r;
  logic [8:0] line_prev_r;
  logic       sync_s1_r;
  logic       sync_s2_r;
  logic       sync_prev_r;
  logic       trip_s1_r;
  logic       trip_s2_r;
  logic       trip_prev_r;

  // Word-index decode; low two address bits select nothing
  wire [6:0] idx        = reg_addr[8:2];
  wire       wr_fsel    = reg_wr && idx == gpi_pkg::IDX_FUNC_SEL;
  wire       wr_dir_lo  = reg_wr && idx == gpi_pkg::IDX_DIR_LOW;
  wire       wr_dir_hi  = reg_wr && idx == gpi_pkg::IDX_DIR_HIGH;
  wire       wr_dat_lo  = reg_wr && idx == gpi_pkg::IDX_DATA_LOW;
  wire       wr_dat_hi  = reg_wr && idx == gpi_pkg::IDX_DATA_HIGH;
  wire       wr_ien_lo  = reg_wr && idx == gpi_pkg::IDX_IEN_LOW;
  wire       wr_ien_hi  = reg_wr && idx == gpi_pkg::IDX_IEN_HIGH;
  wire       wr_strip   = reg_wr && idx == gpi_pkg::IDX_SOFT_TRIP;
  wire       rd_flag_lo = reg_rd && idx == gpi_pkg::IDX_FLAG_LOW;
  wire       rd_flag_hi = reg_rd && idx == gpi_pkg::IDX_FLAG_HIGH;
  wire       rd_stat    = reg_rd && idx == gpi_pkg::IDX_PERIPH_STAT;

  // Per-line mode: lines 0-7 from function select, line 8 from high data bit 1
  wire [8:0] io_mode = {data_high_r[gpi_pkg::DATA_HIGH_MODE_BIT], func_sel_r};
  wire [8:0] io_dir  = {dir_high_r, dir_low_r};
  wire [8:0] io_dat  = {data_high_r[gpi_pkg::DATA_HIGH_LEVEL_BIT], data_low_r};
  wire [8:0] io_ien  = {ien_high_r, ien_low_r};

  // Pin muxing: I/O output only when mode and direction both say so
  wire [8:0] alt_o   = {aux_pwm_out_zero, alt_out};
  wire [8:0] alt_e   = {1'b1, alt_oe};
  assign line_out    = (io_mode & io_dat) | (~io_mode & alt_o);
  assign line_oe     = (io_mode & io_dir) | (~io_mode & alt_e);

  // Interrupt qualification and edge events
  wire [8:0] src_ok     = io_mode & ~io_dir & io_ien;
  wire [8:0] line_edge  = (line_s2_r ^ line_prev_r) & src_ok;
  wire       sync_rise  = sync_s2_r & ~sync_prev_r;
  wire       trip_fall  = ~trip_s2_r & trip_prev_r;
  wire       port_req   = |flag_low_r | flag_high_r;

  // Merged request; held low while anything is pending
  assign peripheral_irq_line_n = ~(port_req | stat_trip_r | stat_sync_r);

  // Read mux; input levels come from the synchronised pins
  logic [gpi_pkg::DATA_W-1:0] rd_mux;
  always_comb begin
    rd_mux = '0;
    case (idx)
      gpi_pkg::IDX_FUNC_SEL:    rd_mux[7:0] = func_sel_r;
      gpi_pkg::IDX_DIR_LOW:     rd_mux[7:0] = dir_low_r;
      gpi_pkg::IDX_DIR_HIGH:    rd_mux[0]   = dir_high_r;
      gpi_pkg::IDX_DATA_LOW:    rd_mux[7:0] = line_s2_r[7:0];
      gpi_pkg::IDX_DATA_HIGH:   rd_mux[1:0] = {data_high_r[1], line_s2_r[8]};
      gpi_pkg::IDX_IEN_LOW:     rd_mux[7:0] = ien_low_r;
      gpi_pkg::IDX_IEN_HIGH:    rd_mux[0]   = ien_high_r;
      gpi_pkg::IDX_FLAG_LOW:    rd_mux[7:0] = flag_low_r;
      gpi_pkg::IDX_FLAG_HIGH:   rd_mux[0]   = flag_high_r;
      gpi_pkg::IDX_PERIPH_STAT: rd_mux[1:0] = {stat_sync_r, stat_trip_r};
      default:                  rd_mux      = '0;
    endcase
  end

  // Read data valid only in the cycle after the strobe; unmapped reads give zero
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rdata_r <= '0;
    end else begin
      rdata_r <= reg_rd ? rd_mux : '0;
    end
  end
  assign reg_rdata = rdata_r;

  // Configuration registers
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      func_sel_r  <= gpi_pkg::FUNC_SEL_RST;
      dir_low_r   <= gpi_pkg::DIR_LOW_RST;
      dir_high_r  <= gpi_pkg::DIR_HIGH_RST;
      data_low_r  <= gpi_pkg::DATA_LOW_RST;
      data_high_r <= gpi_pkg::DATA_HIGH_RST;
      ien_low_r   <= gpi_pkg::IEN_LOW_RST;
      ien_high_r  <= gpi_pkg::IEN_HIGH_RST;
    end else begin
      if (wr_fsel)   func_sel_r  <= reg_wdata[7:0];
      if (wr_dir_lo) dir_low_r   <= reg_wdata[7:0];
      if (wr_dir_hi) dir_high_r  <= reg_wdata[0];
      if (wr_dat_lo) data_low_r  <= reg_wdata[7:0];
      if (wr_dat_hi) data_high_r <= reg_wdata[1:0];
      if (wr_ien_lo) ien_low_r   <= reg_wdata[7:0];
      if (wr_ien_hi) ien_high_r  <= reg_wdata[0];
    end
  end

  // Two-stage synchronisers; first stage feeds only the second
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      line_s1_r   <= '0;
      line_s2_r   <= '0;
      line_prev_r <= '0;
      sync_s1_r   <= 1'b0;
      sync_s2_r   <= 1'b0;
      sync_prev_r <= 1'b0;
      trip_s1_r   <= 1'b1;
      trip_s2_r   <= 1'b1;
      trip_prev_r <= 1'b1;
    end else begin
      line_s1_r   <= line_in;
      line_s2_r   <= line_s1_r;
      line_prev_r <= line_s2_r;
      sync_s1_r   <= pwm_period_sync;
      sync_s2_r   <= sync_s1_r;
      sync_prev_r <= sync_s2_r;
      trip_s1_r   <= pwm_fault_trip_n;
      trip_s2_r   <= trip_s1_r;
      trip_prev_r <= trip_s2_r;
    end
  end

  // Sticky flags: a new event beats the clear-on-read in the same cycle
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      flag_low_r  <= '0;
      flag_high_r <= 1'b0;
      stat_trip_r <= 1'b0;
      stat_sync_r <= 1'b0;
    end else begin
      flag_low_r  <= (rd_flag_lo ? 8'h00 : flag_low_r) | line_edge[7:0];
      flag_high_r <= (rd_flag_hi ? 1'b0 : flag_high_r) | line_edge[8];
      stat_trip_r <= (rd_stat ? 1'b0 : stat_trip_r) | trip_fall | wr_strip;
      stat_sync_r <= (rd_stat ? 1'b0 : stat_sync_r) | sync_rise;
    end
  end

  // Checks
  property p_edge_sets_flag;
    @(posedge clk_sys) disable iff (rst)
      line_edge[0] |=> flag_low_r[0];
  endproperty
  a_edge_sets_flag: assert property (p_edge_sets_flag) else $error("edge did not set flag");

  property p_read_clears;
    @(posedge clk_sys) disable iff (rst)
      (rd_flag_lo && line_edge[7:0] == 8'h00) |=> flag_low_r == 8'h00;
  endproperty
  a_read_clears: assert property (p_read_clears) else $error("flag read did not clear");

  property p_event_survives_read;
    @(posedge clk_sys) disable iff (rst)
      (rd_flag_hi && line_edge[8]) |=> flag_high_r;
  endproperty
  a_event_survives_read: assert property (p_event_survives_read) else $error("event lost on read");

  property p_output_blocks_irq;
    @(posedge clk_sys) disable iff (rst)
      (io_dir[3] || !io_mode[3]) |-> !line_edge[3];
  endproperty
  a_output_blocks_irq: assert property (p_output_blocks_irq) else $error("non-source line flagged");

  property p_irq_holds;
    @(posedge clk_sys) disable iff (rst)
      (port_req && !rd_flag_lo && !rd_flag_hi) |=> !peripheral_irq_line_n;
  endproperty
  a_irq_holds: assert property (p_irq_holds) else $error("interrupt released early");

  property p_sync_rise;
    @(posedge clk_sys) disable iff (rst)
      $rose(sync_s2_r) |=> stat_sync_r ##0 !peripheral_irq_line_n;
  endproperty
  a_sync_rise: assert property (p_sync_rise) else $error("sync edge missed");

  property p_soft_trip;
    @(posedge clk_sys) disable iff (rst)
      wr_strip |=> stat_trip_r;
  endproperty
  a_soft_trip: assert property (p_soft_trip) else $error("soft trip missed");

  property p_stat_read;
    @(posedge clk_sys) disable iff (rst)
      (rd_stat && !wr_strip && !trip_fall && !sync_rise) |=> !stat_trip_r && !stat_sync_r;
  endproperty
  a_stat_read: assert property (p_stat_read) else $error("status read did not acknowledge");

  property p_output_drive;
    @(posedge clk_sys) disable iff (rst)
      (io_mode[0] && io_dir[0]) |-> line_oe[0] && line_out[0] == data_low_r[0];
  endproperty
  a_output_drive: assert property (p_output_drive) else $error("output line not driven");

  property p_line8_mode;
    @(posedge clk_sys) disable iff (rst)
      !data_high_r[1] |-> line_out[8] == aux_pwm_out_zero && line_oe[8];
  endproperty
  a_line8_mode: assert property (p_line8_mode) else $error("line 8 alternate not selected");

  property p_reset_vals;
    @(posedge clk_sys) $fell(rst) |-> func_sel_r == 8'hFF && dir_low_r == 8'h00 && ien_low_r == 8'h00;
  endproperty
  a_reset_vals: assert property (p_reset_vals) else $error("bad reset values");

  // An I/O line set as input must never drive its pin, or the outside driver would fight it
  property p_input_undriven;
    @(posedge clk_sys) disable iff (rst)
      (line_oe & io_mode & ~io_dir) == 9'h000;
  endproperty
  a_input_undriven: assert property (p_input_undriven) else $error("input line driven");

  property p_alt_enable;
    @(posedge clk_sys) disable iff (rst)
      (~io_mode[7:0] & (line_oe[7:0] ^ alt_oe)) == 8'h00;
  endproperty
  a_alt_enable: assert property (p_alt_enable) else $error("alternate enable not passed");

  property p_irq_release;
    @(posedge clk_sys) disable iff (rst)
      (!port_req && !stat_trip_r && !stat_sync_r) |-> peripheral_irq_line_n;
  endproperty
  a_irq_release: assert property (p_irq_release) else $error("interrupt low with nothing pending");

  property p_trip_fall;
    @(posedge clk_sys) disable iff (rst)
      trip_fall |=> stat_trip_r && !peripheral_irq_line_n;
  endproperty
  a_trip_fall: assert property (p_trip_fall) else $error("trip edge missed");

  property p_high_read_clears;
    @(posedge clk_sys) disable iff (rst)
      (rd_flag_hi && !line_edge[8]) |=> !flag_high_r;
  endproperty
  a_high_read_clears: assert property (p_high_read_clears) else $error("high flag read did not clear");

  property p_low_survives;
    @(posedge clk_sys) disable iff (rst)
      (rd_flag_lo && line_edge[4]) |=> flag_low_r[4];
  endproperty
  a_low_survives: assert property (p_low_survives) else $error("low event lost on read");

  // Second stage must copy the first one cycle late; a skipped stage would show here
  property p_sync_chain;
    @(posedge clk_sys) disable iff (rst)
      line_s2_r == $past(line_s1_r);
  endproperty
  a_sync_chain: assert property (p_sync_chain) else $error("synchroniser stage skipped");

  property p_disabled_quiet;
    @(posedge clk_sys) disable iff (rst)
      (io_ien == 9'h000) |-> line_edge == 9'h000;
  endproperty
  a_disabled_quiet: assert property (p_disabled_quiet) else $error("disabled line raised event");

  property p_edge_flag_high;
    @(posedge clk_sys) disable iff (rst)
      line_edge[8] |=> flag_high_r && !peripheral_irq_line_n;
  endproperty
  a_edge_flag_high: assert property (p_edge_flag_high) else $error("line 8 edge not flagged");

  property p_flag_read_data;
    @(posedge clk_sys) disable iff (rst)
      rd_flag_lo |=> reg_rdata[7:0] == $past(flag_low_r);
  endproperty
  a_flag_read_data: assert property (p_flag_read_data) else $error("flag read returned wrong bits");

  // Read data must be zero outside the answer cycle so a stale word is never mistaken for one
  property p_rdata_idle;
    @(posedge clk_sys) disable iff (rst)
      !reg_rd |=> reg_rdata == '0;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside answer cycle");

  property p_output_no_src;
    @(posedge clk_sys) disable iff (rst)
      io_dir[8] |-> !line_edge[8];
  endproperty
  a_output_no_src: assert property (p_output_no_src) else $error("output line 8 flagged");

  property p_line8_io;
    @(posedge clk_sys) disable iff (rst)
      (data_high_r[1] && dir_high_r) |-> line_oe[8] && line_out[8] == data_high_r[0];
  endproperty
  a_line8_io: assert property (p_line8_io) else $error("line 8 output not driven");

  property p_sync_hold;
    @(posedge clk_sys) disable iff (rst)
      (stat_sync_r && !rd_stat) |=> stat_sync_r;
  endproperty
  a_sync_hold: assert property (p_sync_hold) else $error("sync status dropped unread");

endmodule
